// >>> include/kli_defs.svh
`ifndef KLI_DEFS_SVH
`define KLI_DEFS_SVH

// Special function register offsets
`define KLI_OFS_LEVEL_SELECT  8'h9C
`define KLI_OFS_LINE_ENABLE   8'h9D
`define KLI_OFS_LINE_FLAGS    8'h9E
`define KLI_OFS_IRQ_ENABLE1   8'hB1
`define KLI_OFS_PRIO_LOW1     8'hB2
`define KLI_OFS_PRIO_HIGH1    8'hB3

// Field positions and reset values
`define KLI_BIT_GLOBAL_EN     0
`define KLI_BIT_PRIO          0
`define KLI_RST_BYTE          8'h00

// Vector and polling position of the keypad request
`define KLI_VECTOR_ADDR       16'h003B
`define KLI_POLL_POSITION     4'h8

`endif

// >>> include/kli_pkg.sv
package kli_pkg;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } kli_sfr_req_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] rdata;
  } kli_sfr_rsp_t;

  typedef struct packed {
    logic        request;
    logic [1:0]  priority_level;
    logic [15:0] vector_addr;
    logic [3:0]  poll_position;
  } kli_irq_t;

endpackage : kli_pkg

// >>> hdl/kli_line.sv
`timescale 1ns/100ps
`include "kli_defs.svh"

module kli_line (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  input  wire logic polarity_in,
  input  wire logic clear_in,
  output logic      flag_out,
  output logic      level_hit_out
);

  logic sync1_q;
  logic sync2_q;
  logic flag_q;

  // ********************************************
  // Pin synchroniser
  // ********************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Level match: polarity 0 detects low, 1 detects high
  assign level_hit_out = (sync2_q == polarity_in);

  // ********************************************
  // Sticky flag
  // ********************************************
  // A detected level beats a software clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_q <= 1'b0;
    end else if (level_hit_out) begin
      flag_q <= 1'b1;
    end else if (clear_in) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_out = flag_q;

endmodule : kli_line

// >>> hdl/kli_keypad.sv
`timescale 1ns/100ps
`include "kli_defs.svh"


module kli_keypad
  import kli_pkg::*;
#(
  parameter int NUM_LINES = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [NUM_LINES-1:0] port_one_lines_in,
  input  wire kli_sfr_req_t         sfr_req_in,
  output kli_sfr_rsp_t              sfr_rsp_out,
  output kli_irq_t                  irq_out,
  output logic                      keypad_irq_request_out,
  output logic                      wake_out,
  output logic [NUM_LINES-1:0]      keypad_function_out
);

  // ********************************************
  // Elaboration check
  // ********************************************
  if (NUM_LINES < 1 || NUM_LINES > 8) begin : g_bad_width
    $error("NUM_LINES must be 1 to 8");
  end

  logic [NUM_LINES-1:0] polarity_select_bits_q;
  logic [NUM_LINES-1:0] line_mask_bits_q;
  logic [NUM_LINES-1:0] line_flag_bits;
  logic [NUM_LINES-1:0] level_hit;
  logic [NUM_LINES-1:0] flag_clear;
  logic                 keypad_global_enable_q;
  logic                 keypad_priority_high_q;
  logic                 keypad_priority_low_q;
  logic                 request_d;
  logic                 wake_d;
  logic [7:0]           rdata_d;
  logic                 hit_d;
  kli_sfr_rsp_t         rsp_q;
  logic                 request_q;
  logic                 wake_q;

  // ********************************************
  // Register writes
  // ********************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      polarity_select_bits_q <= NUM_LINES'(`KLI_RST_BYTE);
    end else if (sfr_req_in.wr_en && sfr_req_in.addr == `KLI_OFS_LEVEL_SELECT) begin
      polarity_select_bits_q <= sfr_req_in.wdata[NUM_LINES-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_mask_bits_q <= NUM_LINES'(`KLI_RST_BYTE);
    end else if (sfr_req_in.wr_en && sfr_req_in.addr == `KLI_OFS_LINE_ENABLE) begin
      line_mask_bits_q <= sfr_req_in.wdata[NUM_LINES-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      keypad_global_enable_q <= 1'b0;
    end else if (sfr_req_in.wr_en && sfr_req_in.addr == `KLI_OFS_IRQ_ENABLE1) begin
      keypad_global_enable_q <= sfr_req_in.wdata[`KLI_BIT_GLOBAL_EN];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      keypad_priority_low_q  <= 1'b0;
      keypad_priority_high_q <= 1'b0;
    end else if (sfr_req_in.wr_en) begin
      if (sfr_req_in.addr == `KLI_OFS_PRIO_LOW1) begin
        keypad_priority_low_q <= sfr_req_in.wdata[`KLI_BIT_PRIO];
      end
      if (sfr_req_in.addr == `KLI_OFS_PRIO_HIGH1) begin
        keypad_priority_high_q <= sfr_req_in.wdata[`KLI_BIT_PRIO];
      end
    end
  end

  // Software clears a flag by writing zero to its bit; writing one leaves it
  assign flag_clear = (sfr_req_in.wr_en && sfr_req_in.addr == `KLI_OFS_LINE_FLAGS)
                      ? ~sfr_req_in.wdata[NUM_LINES-1:0] : '0;

  // ********************************************
  // Per-line detectors
  // ********************************************
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    kli_line u_line (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .pin_in        (port_one_lines_in[i]),
      .polarity_in   (polarity_select_bits_q[i]),
      .clear_in      (flag_clear[i]),
      .flag_out      (line_flag_bits[i]),
      .level_hit_out (level_hit[i])
    );
  end

  // ********************************************
  // Request and wake
  // ********************************************
  // Flags keep setting while the level persists, so the request rearms itself
  assign request_d = keypad_global_enable_q && |(line_flag_bits & line_mask_bits_q);
  // Wake does not wait for the flag register, so a stopped core still sees it
  assign wake_d    = |(level_hit & line_mask_bits_q);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      request_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      request_q <= request_d;
      wake_q    <= wake_d;
    end
  end

  assign keypad_irq_request_out = request_q;
  assign wake_out               = wake_q;
  // Lines with mask clear stay standard port pins
  assign keypad_function_out    = line_mask_bits_q;

  always_comb begin
    irq_out.request        = request_q;
    irq_out.priority_level = {keypad_priority_high_q, keypad_priority_low_q};
    irq_out.vector_addr    = `KLI_VECTOR_ADDR;
    irq_out.poll_position  = `KLI_POLL_POSITION;
  end

  // ********************************************
  // Register reads
  // ********************************************
  always_comb begin
    rdata_d = 8'h00;
    hit_d   = 1'b1;
    case (sfr_req_in.addr)
      `KLI_OFS_LEVEL_SELECT: rdata_d[NUM_LINES-1:0] = polarity_select_bits_q;
      `KLI_OFS_LINE_ENABLE:  rdata_d[NUM_LINES-1:0] = line_mask_bits_q;
      `KLI_OFS_LINE_FLAGS:   rdata_d[NUM_LINES-1:0] = line_flag_bits;
      `KLI_OFS_IRQ_ENABLE1:  rdata_d[`KLI_BIT_GLOBAL_EN] = keypad_global_enable_q;
      `KLI_OFS_PRIO_LOW1:    rdata_d[`KLI_BIT_PRIO] = keypad_priority_low_q;
      `KLI_OFS_PRIO_HIGH1:   rdata_d[`KLI_BIT_PRIO] = keypad_priority_high_q;
      default:               hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_q <= '0;
    end else if (sfr_req_in.rd_en) begin
      rsp_q.hit   <= hit_d;
      rsp_q.rdata <= rdata_d;
    end else begin
      rsp_q.hit <= 1'b0;
    end
  end

  assign sfr_rsp_out = rsp_q;

endmodule : kli_keypad

// >>> verif/kli_checker.sv
`timescale 1ns/100ps
// ****************
// Keypad checker
// ****************
module kli_checker
  import kli_pkg::*;
#(
  parameter int NUM_LINES = 8
) (
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire logic [NUM_LINES-1:0] port_one_lines_in,
  input wire kli_sfr_req_t         sfr_req_in,
  input wire kli_sfr_rsp_t         sfr_rsp_out,
  input wire kli_irq_t             irq_out,
  input wire logic                 keypad_irq_request_out,
  input wire logic                 wake_out,
  input wire logic [NUM_LINES-1:0] keypad_function_out
);
  logic mapped;
  assign mapped = sfr_req_in.addr inside {8'h9C, 8'h9D, 8'h9E, 8'hB1, 8'hB2, 8'hB3};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd_mapped;
    sfr_req_in.rd_en && mapped;
  endsequence
  sequence s_rd_unmapped;
    sfr_req_in.rd_en && !mapped;
  endsequence
  a_req_mirror: assert property (keypad_irq_request_out == irq_out.request)
    else $error("request outputs disagree");
  a_vector_fixed: assert property (irq_out.vector_addr == 16'h003B && irq_out.poll_position == 4'h8)
    else $error("vector or poll position wrong");
  a_func_by_write: assert property ($changed(keypad_function_out)
    |-> $past(sfr_req_in.wr_en && sfr_req_in.addr == 8'h9D))
    else $error("pin function changed without a mask write");
  a_hit_mapped: assert property (s_rd_mapped |=> sfr_rsp_out.hit)
    else $error("mapped read gave no hit");
  a_miss_unmapped: assert property (s_rd_unmapped |=> !sfr_rsp_out.hit)
    else $error("unmapped read gave a hit");
  a_req_masked: assert property ($rose(keypad_irq_request_out)
    |-> $past(keypad_function_out != '0))
    else $error("request rose with every line masked");
  a_req_sticky: assert property (keypad_irq_request_out && !sfr_req_in.wr_en
    && !$past(sfr_req_in.wr_en) |=> keypad_irq_request_out)
    else $error("request fell without a register write");
  a_no_wake_io: assert property (keypad_function_out == '0 [*2] |-> !wake_out)
    else $error("wake raised with every line masked");
endmodule : kli_checker
bind kli_keypad kli_checker #(.NUM_LINES(NUM_LINES)) u_kli_checker (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .port_one_lines_in(port_one_lines_in),
  .sfr_req_in(sfr_req_in), .sfr_rsp_out(sfr_rsp_out), .irq_out(irq_out),
  .keypad_irq_request_out(keypad_irq_request_out), .wake_out(wake_out),
  .keypad_function_out(keypad_function_out));

// >>> verif/kli_key_model.sv
`timescale 1ns/100ps
// Pull-ups hold released lines high; a pressed key shorts its line low
module kli_key_model (
  input  wire logic [7:0] press_in,
  output logic      [7:0] lines_out
);
  assign lines_out = ~press_in;
endmodule : kli_key_model

// >>> verif/kli_keypad_tb.sv
`timescale 1ns/100ps
module kli_keypad_tb;
  import kli_pkg::*;
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic [7:0]   press_q = 8'h00;
  logic [7:0]   lines;
  kli_sfr_req_t req = '0;
  kli_sfr_rsp_t rsp;
  kli_irq_t     irq;
  logic         irq_req;
  logic         wake;
  logic [7:0]   func;
  int           err_count = 0;
  int           checks_done = 0;
  always #2.5 clk_in = ~clk_in;
  kli_key_model u_kli_key_model (.press_in(press_q), .lines_out(lines));
  kli_keypad u_kli_keypad (.clk_in(clk_in), .rst_n_in(rst_n_in), .port_one_lines_in(lines),
    .sfr_req_in(req), .sfr_rsp_out(rsp), .irq_out(irq), .keypad_irq_request_out(irq_req),
    .wake_out(wake), .keypad_function_out(func));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in);
    req <= '0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(string n, logic [7:0] a, logic [7:0] e, logic h);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1 chk({n, "_hit"}, {7'h00, h}, {7'h00, rsp.hit});
    if (h) chk(n, e, rsp.rdata);
    @(posedge clk_in);
  endtask : rd
  task automatic settle;
    repeat (5) @(posedge clk_in);
  endtask : settle
  task automatic t_reset;
    rd("polarity", 8'h9C, 8'h00, 1'b1);
    rd("mask", 8'h9D, 8'h00, 1'b1);
    rd("flags", 8'h9E, 8'h00, 1'b1);
    rd("unmapped", 8'h00, 8'h00, 1'b0);
  endtask : t_reset
  task automatic t_lines;
    for (int n = 0; n < 8; n++) begin
      press_q <= 8'h01 << n;
      settle();
      rd("low_flag", 8'h9E, 8'h01 << n, 1'b1);
      press_q <= 8'h00;
      settle();
      rd("kept_flag", 8'h9E, 8'h01 << n, 1'b1);
      wr(8'h9E, 8'h00);
      rd("clr_flag", 8'h9E, 8'h00, 1'b1);
      wr(8'h9C, 8'h01 << n);
      settle();
      rd("high_flag", 8'h9E, 8'h01 << n, 1'b1);
      wr(8'h9C, 8'h00);
      wr(8'h9E, 8'h00);
    end
  endtask : t_lines
  task automatic t_request;
    press_q <= 8'h04;
    wr(8'hB1, 8'h01);
    settle();
    chk("req_masked", 8'h00, {7'h00, irq_req});
    chk("func_io", 8'h00, func);
    wr(8'h9D, 8'h04);
    settle();
    chk("req_on", 8'h01, {7'h00, irq_req});
    chk("wake_on", 8'h01, {7'h00, wake});
    chk("func_kbd", 8'h04, func);
    wr(8'hB1, 8'h00);
    settle();
    chk("req_gated", 8'h00, {7'h00, irq_req});
    chk("wake_ungated", 8'h01, {7'h00, wake});
    wr(8'hB1, 8'h01);
    wr(8'h9E, 8'h00);
    rd("reset_flag", 8'h9E, 8'h04, 1'b1);
    press_q <= 8'h00;
    settle();
    wr(8'h9E, 8'h00);
    settle();
    chk("req_off", 8'h00, {7'h00, irq_req});
  endtask : t_request
  task automatic t_prio;
    wr(8'hB2, 8'h01);
    wr(8'hB3, 8'h01);
    settle();
    chk("prio", 8'h03, {6'h00, irq.priority_level});
    rd("prio_hi", 8'hB3, 8'h01, 1'b1);
    chk("vector", 8'h3B, irq.vector_addr[7:0]);
  endtask : t_prio
  task automatic report_and_stop;
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_lines();
    t_request();
    t_prio();
    report_and_stop();
  end
endmodule : kli_keypad_tb
